// ==== jesd_rx_model.sv ====
`timescale 1ns/1ps
module jesd_rx_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic request_i,
    input wire logic lmfc_edge_i,
    output logic sync_n_o
);
    logic [2:0] seen;
    // ==========
    // Link request, wait out CGS, release on a multiframe edge.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_n_o <= 1'b1;
            seen <= 3'h0;
        end else if (sync_n_o) begin
            if (request_i && seen == 3'h0) sync_n_o <= 1'b0;
            if (!request_i) seen <= 3'h0;
        end else if (seen != 3'h4) seen <= seen + 3'h1;
        else if (lmfc_edge_i) sync_n_o <= 1'b1;
    end
endmodule // jesd_rx_model

// ==== jesd_transport_scrambler_tx.sv ====
`timescale 1ns/1ps
module jesd_transport_scrambler_tx (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sample_valid_i,
    input wire logic [35:0] sample_data_i,
    output logic sample_ready_o,
    input wire logic [2:0] transport_mode_select_i,
    input wire logic [8:0] k_frames_i,
    input wire logic scramble_enable_i,
    input wire logic fec_enable_i,
    input wire logic nco_sync_select_i,
    input wire logic single_channel_variant_i,
    input wire logic sync_request_pin_n_i,
    input wire logic sysref_i,
    output logic [63:0] lane_octet_o,
    output logic lane_data_valid_o,
    output logic [7:0] lane_enable_o,
    output logic [511:0] block_data_o,
    output logic block_valid_o,
    output logic frame_end_o,
    output logic lmfc_edge_o,
    output logic [1:0] link_phase_o,
    output logic encoding_64b66b_o,
    output logic fec_active_o,
    output logic link_init_request_o,
    output logic nco_sync_o,
    output logic config_error_o
);
    // =========================================================
    // Scrambler functions
    // =========================================================
    function automatic logic [22:0] scr8(input logic [7:0] d, input logic [14:0] st);
        logic [14:0] s;
        logic [7:0] o;
        s = st;
        o = '0;
        for (int b = 7; b >= 0; b--) begin
            o[b] = d[b] ^ s[jesd_tx_pkg::SCR8_TAP_A] ^ s[jesd_tx_pkg::SCR8_TAP_B];
            s = {s[13:0], o[b]};
        end
        return {o, s};
    endfunction

    function automatic logic [121:0] scr64(input logic [63:0] d, input logic [57:0] st);
        logic [57:0] s;
        logic [63:0] o;
        s = st;
        o = '0;
        for (int b = 63; b >= 0; b--) begin
            o[b] = d[b] ^ s[jesd_tx_pkg::SCR64_TAP_A] ^ s[jesd_tx_pkg::SCR64_TAP_B];
            s = {s[56:0], o[b]};
        end
        return {o, s};
    endfunction

    // =========================================================
    // Pin synchronisers
    // =========================================================
    logic [2:0] sync_pipe;
    logic [2:0] sysref_pipe;
    logic sync_s;
    logic sync_fall;
    logic sysref_edge;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_pipe <= 3'h7;
        end else begin
            sync_pipe <= {sync_pipe[1:0], sync_request_pin_n_i};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sysref_pipe <= 3'h0;
        end else begin
            sysref_pipe <= {sysref_pipe[1:0], sysref_i};
        end
    end

    assign sync_s = sync_pipe[1];
    assign sync_fall = sync_pipe[2] && !sync_pipe[1];
    assign sysref_edge = sysref_pipe[1] && !sysref_pipe[2];

    // =========================================================
    // Mode decode and parameter check
    // =========================================================
    logic [3:0] lanes_l;
    logic [3:0] lanes_eff;
    logic [4:0] octets_f;
    logic enc64;
    logic [13:0] kf;
    logic [13:0] period;
    logic cfg_ok;
    logic [2:0] last_phase;

    assign lanes_l = jesd_tx_pkg::MODE_LANES[transport_mode_select_i];
    assign octets_f = jesd_tx_pkg::MODE_OCTETS[transport_mode_select_i];
    assign enc64 = jesd_tx_pkg::MODE_ENC64[transport_mode_select_i];
    // The single channel variant never drives more than its four lanes.
    assign lanes_eff = (single_channel_variant_i
                        && lanes_l > 4'(jesd_tx_pkg::SINGLE_LANES))
                       ? 4'(jesd_tx_pkg::SINGLE_LANES) : lanes_l;
    assign last_phase = 3'((4'h8 / lanes_eff) - 4'h1);
    assign kf = 14'(octets_f) * 14'(k_frames_i);
    assign period = enc64 ? (14'(k_frames_i) << jesd_tx_pkg::EMB_SHIFT) : kf;

    always_comb begin
        if (enc64) begin
            cfg_ok = (k_frames_i != '0) && (k_frames_i <= jesd_tx_pkg::EMB_MAX);
        end else begin
            cfg_ok = (kf >= jesd_tx_pkg::KF_MIN) && (kf <= jesd_tx_pkg::KF_MAX)
                     && (k_frames_i <= jesd_tx_pkg::K_MAX);
        end
    end

    // =========================================================
    // Multiframe, block and frame counters
    // =========================================================
    logic [13:0] lmfc_cnt;
    logic lmfc_wrap;
    logic [4:0] frame_cnt;

    assign lmfc_wrap = (lmfc_cnt == period - 14'h0001);

    // Octet count within a multiframe, or within an extended multiblock
    // whose low three bits give the octet position inside a block.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lmfc_cnt <= '0;
        end else if (sysref_edge || lmfc_wrap) begin
            lmfc_cnt <= '0;
        end else begin
            lmfc_cnt <= lmfc_cnt + 14'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_cnt <= '0;
        end else if (sysref_edge || frame_cnt == octets_f - 5'h01) begin
            frame_cnt <= '0;
        end else begin
            frame_cnt <= frame_cnt + 5'h01;
        end
    end

    // =========================================================
    // Link start sequence
    // =========================================================
    jesd_tx_pkg::link_state_t state;
    logic [1:0] ilas_cnt;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= jesd_tx_pkg::LINK_CGS;
            ilas_cnt <= '0;
        end else if (enc64) begin
            state <= jesd_tx_pkg::LINK_DATA;
        end else if (!sync_s) begin
            state <= jesd_tx_pkg::LINK_CGS;
        end else begin
            case (state)
                jesd_tx_pkg::LINK_CGS: begin
                    state <= jesd_tx_pkg::LINK_WAIT_LMFC;
                end
                jesd_tx_pkg::LINK_WAIT_LMFC: begin
                    if (lmfc_wrap) begin
                        state <= jesd_tx_pkg::LINK_ILAS;
                        ilas_cnt <= '0;
                    end
                end
                jesd_tx_pkg::LINK_ILAS: begin
                    if (lmfc_wrap) begin
                        if (ilas_cnt == jesd_tx_pkg::ILAS_LAST) begin
                            state <= jesd_tx_pkg::LINK_DATA;
                        end else begin
                            ilas_cnt <= ilas_cnt + 2'h1;
                        end
                    end
                end
                jesd_tx_pkg::LINK_DATA: begin
                    state <= jesd_tx_pkg::LINK_DATA;
                end
                default: begin
                    state <= jesd_tx_pkg::LINK_CGS;
                end
            endcase
        end
    end

    // =========================================================
    // Sample packing and buffering
    // =========================================================
    logic [63:0] packed_word;
    logic fifo_valid;
    logic [63:0] fifo_data;
    logic in_data;
    logic pop;
    logic [2:0] phase;

    // Each 9-bit sample sits MSB-aligned in a 16-bit field, tail bits zero.
    always_comb begin
        packed_word = '0;
        for (int c = 0; c < jesd_tx_pkg::CONVERTERS; c++) begin
            packed_word[c*jesd_tx_pkg::FIELD_W+jesd_tx_pkg::FIELD_W-1 -:
                        jesd_tx_pkg::SAMPLE_W] =
                sample_data_i[c*jesd_tx_pkg::SAMPLE_W +: jesd_tx_pkg::SAMPLE_W];
        end
    end

    assign in_data = (state == jesd_tx_pkg::LINK_DATA) && fifo_valid;
    assign pop = in_data && (phase == last_phase);

    stream_fifo #(
        .WIDTH(jesd_tx_pkg::WORD_W),
        .DEPTH(jesd_tx_pkg::FIFO_DEPTH)
    ) sample_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(sample_valid_i),
        .in_data_i(packed_word),
        .in_ready_o(sample_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(pop)
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= '0;
        end else if (in_data) begin
            phase <= (phase == last_phase) ? 3'h0 : phase + 3'h1;
        end
    end

    // =========================================================
    // Octet to lane mapping
    // =========================================================
    logic [63:0] raw_octets;
    logic scr8_on;

    // Lane i carries octet phase*lanes_eff + i of the current word.
    always_comb begin
        logic [6:0] idx;
        idx = '0;
        raw_octets = '0;
        for (int i = 0; i < jesd_tx_pkg::LANES; i++) begin
            idx = 7'(phase) * 7'(lanes_eff) + 7'(i);
            if (in_data && 4'(i) < lanes_eff) begin
                raw_octets[i*8 +: 8] = fifo_data[idx[2:0]*8 +: 8];
            end
        end
    end

    // Start-up sequences pass raw so the link layer can overlay them.
    assign scr8_on = !enc64 && scramble_enable_i
                     && (state == jesd_tx_pkg::LINK_DATA);

    // =========================================================
    // Per-lane scramblers
    // =========================================================
    for (genvar g = 0; g < jesd_tx_pkg::LANES; g++) begin : lane_g
        logic [14:0] s8;
        logic [57:0] s64;
        logic [63:0] acc;
        logic [22:0] r8;
        logic [121:0] r64;

        assign r8 = scr8(raw_octets[g*8 +: 8], s8);
        assign r64 = scr64({acc[55:0], raw_octets[g*8 +: 8]}, s64);

        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s8 <= jesd_tx_pkg::SCR8_RESET;
                lane_octet_o[g*8 +: 8] <= '0;
            end else begin
                if (scr8_on) begin
                    s8 <= r8[14:0];
                end
                lane_octet_o[g*8 +: 8] <= scr8_on ? r8[22:15]
                                                 : raw_octets[g*8 +: 8];
            end
        end

        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s64 <= jesd_tx_pkg::SCR64_RESET;
                acc <= '0;
                block_data_o[g*64 +: 64] <= '0;
            end else if (enc64) begin
                acc <= {acc[55:0], raw_octets[g*8 +: 8]};
                if (lmfc_cnt[2:0] == jesd_tx_pkg::BLOCK_LAST) begin
                    s64 <= r64[57:0];
                    block_data_o[g*64 +: 64] <= r64[121:58];
                end
            end
        end
    end

    // =========================================================
    // Status and side outputs
    // =========================================================
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            block_valid_o <= 1'b0;
            lane_data_valid_o <= 1'b0;
            lane_enable_o <= '0;
            frame_end_o <= 1'b0;
            lmfc_edge_o <= 1'b0;
            encoding_64b66b_o <= 1'b0;
            config_error_o <= 1'b0;
        end else begin
            block_valid_o <= enc64 && lmfc_cnt[2:0] == jesd_tx_pkg::BLOCK_LAST;
            lane_data_valid_o <= in_data;
            lane_enable_o <= 8'((9'h001 << lanes_eff) - 9'h001);
            frame_end_o <= !enc64 && frame_cnt == octets_f - 5'h01;
            lmfc_edge_o <= lmfc_wrap;
            encoding_64b66b_o <= enc64;
            config_error_o <= !cfg_ok;
        end
    end

    // FEC and the link layer encoding sit downstream; neither a three-bit
    // CRC nor a command channel is ever requested from them.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fec_active_o <= 1'b0;
            link_init_request_o <= 1'b0;
            nco_sync_o <= 1'b0;
        end else begin
            fec_active_o <= enc64 && fec_enable_i;
            link_init_request_o <= !enc64 && !sync_s;
            nco_sync_o <= enc64 && nco_sync_select_i && sync_fall;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_phase_o <= jesd_tx_pkg::PHASE_CGS;
        end else begin
            case (state)
                jesd_tx_pkg::LINK_CGS: begin
                    link_phase_o <= jesd_tx_pkg::PHASE_CGS;
                end
                jesd_tx_pkg::LINK_WAIT_LMFC: begin
                    link_phase_o <= jesd_tx_pkg::PHASE_WAIT;
                end
                jesd_tx_pkg::LINK_ILAS: begin
                    link_phase_o <= jesd_tx_pkg::PHASE_ILAS;
                end
                default: begin
                    link_phase_o <= jesd_tx_pkg::PHASE_DATA;
                end
            endcase
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    sequence ilas_entry_s;
        !enc64 && sync_s && state == jesd_tx_pkg::LINK_WAIT_LMFC && lmfc_wrap;
    endsequence

    sequence lane_raw_s;
        ##1 lane_octet_o == $past(raw_octets);
    endsequence

    sysref_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sysref_edge |=> lmfc_cnt == 14'h0000)
        else $error("SYSREF did not clear the multiframe counter");

    ilas_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ilas_entry_s |=> state == jesd_tx_pkg::LINK_ILAS)
        else $error("Alignment sequence did not start on the multiframe edge");

    ilas_plain_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state == jesd_tx_pkg::LINK_ILAS |-> lane_raw_s)
        else $error("Alignment sequence octets were scrambled");

    scr_bypass_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !enc64 && !scramble_enable_i |-> lane_raw_s)
        else $error("Octets scrambled with scrambling disabled");

    sync_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        enc64 [*2] |-> state == jesd_tx_pkg::LINK_DATA && !link_init_request_o)
        else $error("SYNC acted on the link in 64B/66B mode");

    sync_restart_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !enc64 && !sync_s |=> state == jesd_tx_pkg::LINK_CGS && link_init_request_o)
        else $error("SYNC low did not restart the link");

    single_lanes_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $stable(single_channel_variant_i) && single_channel_variant_i
        |=> lane_enable_o[7:4] == 4'h0)
        else $error("Single channel variant enabled more than four lanes");

    pop_data_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state != jesd_tx_pkg::LINK_DATA |=> !lane_data_valid_o && lane_octet_o == 64'h0)
        else $error("Lane octets carried data outside the data phase");

    block_cadence_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        block_valid_o |-> $past(lmfc_cnt[2:0]) == 3'h7 && $past(enc64))
        else $error("Scrambled block emitted off its block boundary");

    k_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !enc64 && (kf < jesd_tx_pkg::KF_MIN || kf > jesd_tx_pkg::KF_MAX) |=> config_error_o)
        else $error("Illegal multiframe length not flagged");
endmodule // jesd_transport_scrambler_tx

// ==== jesd_transport_scrambler_tx_test.sv ====
`timescale 1ns/1ps
module jesd_transport_scrambler_tx_test;
    logic clock_i = 1'b0, rst_n_i = 1'b0, sample_valid_i = 1'b0, sysref_i = 1'b0;
    logic fec_enable_i = 1'b0, single_channel_variant_i = 1'b0, request = 1'b0;
    logic scramble_enable_i = 1'b0, nco_sync_select_i = 1'b0;
    logic [35:0] sample_data_i = 36'h0;
    logic [2:0] transport_mode_select_i = 3'h0;
    logic [8:0] k_frames_i = 9'h020;
    logic sync_request_pin_n_i, sample_ready_o, lane_data_valid_o, block_valid_o, lmfc_edge_o;
    logic encoding_64b66b_o, fec_active_o, link_init_request_o, config_error_o;
    logic frame_end_o, nco_sync_o;
    logic [511:0] block_data_o;
    logic [63:0] lane_octet_o;
    logic [7:0] lane_enable_o;
    logic [1:0] link_phase_o;
    int n_errors = 0, comparisons = 0;
    jesd_transport_scrambler_tx DUT (.clock_i, .rst_n_i, .sample_valid_i, .sample_data_i,
        .sample_ready_o, .transport_mode_select_i, .k_frames_i, .scramble_enable_i,
        .fec_enable_i, .nco_sync_select_i, .single_channel_variant_i, .sync_request_pin_n_i,
        .sysref_i, .lane_octet_o, .lane_data_valid_o, .lane_enable_o, .block_data_o,
        .block_valid_o, .frame_end_o, .lmfc_edge_o, .link_phase_o, .encoding_64b66b_o,
        .fec_active_o, .link_init_request_o, .nco_sync_o, .config_error_o);
    jesd_rx_model partner (.clock_i, .rst_n_i, .request_i(request), .lmfc_edge_i(lmfc_edge_o),
        .sync_n_o(sync_request_pin_n_i));
    initial forever #5 clock_i = ~clock_i;
    // ==========
    // Helpers and scenarios.
    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        comparisons++;
        if (seen !== exp) n_errors++;
        if (seen !== exp) $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    endtask
    // Receiver side descrambler: it feeds back received bits, starting from the same all-zero seed as the scrambler.
    function automatic logic [22:0] unscramble(input logic [7:0] o, input logic [14:0] st);
        logic [7:0] d;
        logic [14:0] s;
        s = st;
        for (int b = 7; b >= 0; b--) begin
            d[b] = o[b] ^ s[13] ^ s[14];
            s = {s[13:0], o[b]};
        end
        return {d, s};
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick;
        @(posedge clock_i);
        #1;
    endtask
    task automatic restart(input logic [12:0] mk);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        {scramble_enable_i, transport_mode_select_i, k_frames_i} <= mk;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) tick();
    endtask
    task automatic next_edge(output int n);
        for (n = 0; n < 999 && !(n > 0 && lmfc_edge_o === 1'b1); n++) tick();
    endtask
    task automatic stream_test(input logic scramble_enable);
        logic [63:0] w, got;
        logic [14:0] ds [8];
        int j;
        request <= 1'b0;
        restart({scramble_enable, 3'h0, 9'h020});
        for (j = 0; j < 8; j++) ds[j] = 15'h0000;
        for (j = 0; j < 9; j++) begin
            @(posedge clock_i);
            sample_valid_i <= (j < 8);
            for (int c = 0; c < 4; c++) sample_data_i[9*c+:9] <= 9'(9'h101 + j * 4 + c);
        end
        #1;
        check("fill", {sample_ready_o, lane_enable_o}, {1'b0, 8'hFF});
        request <= 1'b1;
        for (j = 0; j < 20 && link_init_request_o !== 1'b1; j++) tick();
        tick();
        check("init", {link_init_request_o, link_phase_o}, {1'b1, 2'h0});
        j = 0;
        for (int i = 0; i < 900 && j < 8; i++) begin
            tick();
            got = lane_octet_o;
            if (scramble_enable && link_phase_o === 2'h3)
                for (int g = 0; g < 8; g++)
                    {got[8*g+:8], ds[g]} = unscramble(lane_octet_o[8*g+:8], ds[g]);
            if (lane_data_valid_o === 1'b1) begin
                for (int c = 0; c < 4; c++) w[16*c+:16] = {9'(9'h101 + j * 4 + c), 7'h00};
                check("octets", {link_phase_o, got}, {2'h3, w});
                j++;
            end
        end
        check("words", 80'(j), 80'h8);
        $display("stream_test done");
    endtask
    task automatic period_test;
        int n, f, d[2];
        for (int m = 0; m < 4; m++) begin
            restart({3'(m), 9'h020});
            next_edge(n);
            next_edge(n);
            check("period", {config_error_o, 64'(n)}, {1'b0, 64'(32 << m)});
            f = 0;
            repeat (8) begin
                tick();
                f += 32'(frame_end_o === 1'b1);
            end
            check("frames", 80'(f), 80'(8 >> m));
        end
        for (int r = 0; r < 2; r++) begin
            next_edge(n);
            repeat (r * 5 + 3) @(posedge clock_i);
            sysref_i <= 1'b1;
            @(posedge clock_i);
            sysref_i <= 1'b0;
            next_edge(d[r]);
        end
        check("sysref", 80'(d[0]), 80'(d[1]));
        restart({3'h3, 9'h081});
        check("k_high", config_error_o, 1'b1);
        $display("period_test done");
    endtask
    task automatic enc64_test;
        int n = 0, k = 0;
        fec_enable_i <= 1'b1;
        single_channel_variant_i <= 1'b1;
        nco_sync_select_i <= 1'b1;
        request <= 1'b1;
        restart({3'h4, 9'h001});
        repeat (64) begin
            tick();
            n += 32'(block_valid_o === 1'b1);
            k += 32'(nco_sync_o === 1'b1);
        end
        check("blocks", 80'(n), 80'h8);
        check("nco", 80'(k), 80'h1);
        check("zero_block", 80'(block_data_o != 512'h0), 80'h0);
        check("phase64", {link_phase_o, link_init_request_o}, {2'h3, 1'b0});
        check("enc64", {encoding_64b66b_o, fec_active_o, lane_enable_o}, 10'h30F);
        $display("enc64_test done");
    endtask
    initial begin
        stream_test(1'b0);
        stream_test(1'b1);
        period_test();
        enc64_test();
        end_of_test();
    end
    initial begin
        #300000;
        n_errors++;
        end_of_test();
    end
endmodule // jesd_transport_scrambler_tx_test

// ==== jesd_tx_pkg.sv ====
package jesd_tx_pkg;
    localparam int LANES = 8;
    localparam int SINGLE_LANES = 4;
    localparam int OCTET_W = 8;
    localparam int WORD_W = 64;
    localparam int CONVERTERS = 4;
    localparam int SAMPLE_W = 9;
    localparam int FIELD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int MODE_W = 3;
    localparam int MODES = 8;
    localparam int K_W = 9;
    localparam int CNT_W = 14;
    localparam int FRAME_W = 5;
    localparam int PHASE_W = 3;
    localparam int SCR8_W = 15;
    localparam int SCR64_W = 58;
    // Self-synchronous taps: 1 + x^14 + x^15 and 1 + x^39 + x^58.
    localparam int SCR8_TAP_A = 13;
    localparam int SCR8_TAP_B = 14;
    localparam int SCR64_TAP_A = 38;
    localparam int SCR64_TAP_B = 57;
    localparam logic [SCR8_W-1:0] SCR8_RESET = 15'h0000;
    localparam logic [SCR64_W-1:0] SCR64_RESET = 58'h000_0000_0000_0000;
    localparam logic [K_W-1:0] K_MAX = 9'h100;
    localparam logic [13:0] KF_MIN = 14'h0011;
    localparam logic [13:0] KF_MAX = 14'h0400;
    localparam logic [K_W-1:0] EMB_MAX = 9'h010;
    localparam int EMB_SHIFT = 8;
    localparam logic [2:0] BLOCK_LAST = 3'h7;
    localparam logic [1:0] ILAS_LAST = 2'h3;
    localparam logic [3:0] MODE_LANES [0:MODES-1] =
        '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h4, 4'h2, 4'h1};
    localparam logic [FRAME_W-1:0] MODE_OCTETS [0:MODES-1] =
        '{5'h01, 5'h02, 5'h04, 5'h08, 5'h01, 5'h02, 5'h04, 5'h08};
    localparam logic MODE_ENC64 [0:MODES-1] =
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam logic [1:0] PHASE_CGS = 2'h0;
    localparam logic [1:0] PHASE_WAIT = 2'h1;
    localparam logic [1:0] PHASE_ILAS = 2'h2;
    localparam logic [1:0] PHASE_DATA = 2'h3;
    typedef enum {LINK_CGS, LINK_WAIT_LMFC, LINK_ILAS, LINK_DATA} link_state_t;
endpackage

// ==== stream_fifo.sv ====
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // stream_fifo
